/* File: bench/remote_node.sv */
`timescale 1ns/10ps
// Far-end serial node; line idles high between frames
module remote_node (
    // Clock
    input wire logic clk,
    // Serial line
    output logic rxd,
    input wire logic txd
);
    initial rxd = 1'b1;

    // LSB first; stop value is a parameter so faults can be injected
    task automatic send(input logic [8:0] data, input int nbits, input logic stop, input int bitcyc);
        @(posedge clk) #1;
        rxd = 1'b0;
        repeat (bitcyc) @(posedge clk);
        for (int i = 0; i < nbits; i++)
        begin
            #1 rxd = data[i];
            repeat (bitcyc) @(posedge clk);
        end
        #1 rxd = stop;
        repeat (bitcyc) @(posedge clk);
        #1 rxd = 1'b1;
    endtask

    // Disconnected master: line held low
    task automatic hold_low(input int cycles);
        @(posedge clk) #1;
        rxd = 1'b0;
        repeat (cycles) @(posedge clk);
        #1 rxd = 1'b1;
    endtask

    // Takes one frame at 16 clocks a bit, sampled mid-bit
    task automatic recv(output logic [7:0] data, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        ok = (n < 2000);
        repeat (24) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            data[i] = txd;
            repeat (16) @(posedge clk);
        end
    endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import uart_frac_pkg::*;
    logic clk;
    logic rst;
    sfr_req_s sfr;
    logic [7:0] sfr_rdata;
    logic rxd;
    logic txd;
    logic wake;
    int errors = 0;
    int check_count = 0;
    int wakes = 0;
    logic [7:0] b;
    logic ok;

    uart_frac_baud_error_check i_uart_frac_baud_error_check (
        .clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .rxd(rxd), .txd(txd), .wake(wake));
    remote_node u_remote (.clk(clk), .rxd(rxd), .txd(txd));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
        if (wake === 1'b1)
            wakes++;

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk) #1;
        sfr.wr = 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name, input logic [7:0] m = 8'hff);
        @(posedge clk) #1;
        sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk) #1;
        sfr.rd = 1'b0;
        check(name, exp & m, sfr_rdata & m);
    endtask

    task automatic rx(input logic [8:0] d, input int nb, input logic stop);
        u_remote.send(d, nb, stop, 16);
        repeat (4) @(posedge clk);
    endtask

    // Bit 0 of byte 0x01 is one high bit time, free of the start phase
    task automatic meas_bit(input int exp);
        int n;
        n = 0;
        wr(ADDR_SERIAL_DATA_BUFFER, 8'h01);
        while (txd !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (txd === 1'b0 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (txd === 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        // Fractional steps may jitter one clock
        check("bit length ok", 8'h01, {7'h0, n >= exp - 1 && n <= exp + 1});
        repeat (11 * exp) @(posedge clk);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #(8 * 60000);
        errors++;
        end_sim;
    end

    initial
    begin
        int h;
        sfr = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        rdc(ADDR_SERIAL_PORT_CONTROL, 8'h00, "port control reset");
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "baud reset");
        rdc(ADDR_CHIP_CONFIGURATION, 8'h00, "cfg reset");
        rdc(8'h55, 8'h00, "unmapped");
        // Classic mode
        wr(ADDR_SERIAL_PORT_CONTROL, 8'h10);
        rx(9'h0a5, 8, 1'b1);
        rdc(ADDR_SERIAL_PORT_CONTROL, 8'h15, "stop in ninth bit");
        check("wake seen", 8'h01, {7'h0, wakes > 0});
        rx(9'h03c, 8, 1'b1);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "no classic overwrite");
        rdc(ADDR_SERIAL_DATA_BUFFER, 8'ha5, "frame dropped");
        wr(ADDR_SERIAL_PORT_CONTROL, 8'h30);
        rx(9'h066, 8, 1'b0);
        rdc(ADDR_SERIAL_PORT_CONTROL, 8'h30, "mp rejects");
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "no classic framing");
        // Extended mode
        wr(ADDR_CHIP_CONFIGURATION, 8'h01);
        wr(ADDR_SERIAL_PORT_CONTROL, 8'h10);
        rx(9'h000, 8, 1'b0);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h40, "framing 8 bit");
        wr(ADDR_BAUD_TIMER_CONTROL, 8'h00);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "framing cleared");
        rx(9'h011, 8, 1'b1);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h80, "overwrite");
        rdc(ADDR_SERIAL_DATA_BUFFER, 8'h11, "accepted");
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "ovr cleared");
        wr(ADDR_SERIAL_PORT_CONTROL, 8'h90);
        rx(9'h1ff, 9, 1'b0);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h40, "framing 9 bit");
        // 160 clocks is under the 176-tick threshold
        u_remote.hold_low(160);
        repeat (40) @(posedge clk);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h00, "no break", 8'h20);
        u_remote.hold_low(200);
        repeat (40) @(posedge clk);
        rdc(ADDR_BAUD_TIMER_CONTROL, 8'h20, "break", 8'h20);
        // Transmit, fast and divided rates
        wr(ADDR_CHIP_CONFIGURATION, 8'h00);
        wr(ADDR_BAUD_TIMER_CONTROL, 8'h00);
        wr(ADDR_SERIAL_PORT_CONTROL, 8'h00);
        fork
            u_remote.recv(b, ok);
            wr(ADDR_SERIAL_DATA_BUFFER, 8'h5a);
        join
        check("tx byte", 8'h5a, b);
        check("tx seen", 8'h01, {7'h0, ok});
        repeat (40) @(posedge clk);
        rdc(ADDR_SERIAL_PORT_CONTROL, 8'h02, "tx done flag", 8'h02);
        wr(ADDR_BAUD_TIMER_CONTROL, 8'h01);
        wr(ADDR_BAUD_FRACTION, 8'h20);
        meas_bit(48);
        wr(ADDR_BAUD_FRACTION, 8'h00);
        wr(ADDR_BAUD_TIMER_CONTROL, 8'h09);
        meas_bit(64);
        // Carrier needs a bit longer than its half period
        wr(ADDR_BAUD_TIMER_CONTROL, 8'h07);
        wr(ADDR_CHIP_CONFIGURATION, 8'h02);
        wr(ADDR_SERIAL_DATA_BUFFER, 8'h01);
        h = 0;
        repeat (2000)
        begin
            @(posedge clk);
            if (txd === 1'b1)
                h++;
        end
        check("carrier on line", 8'h01, {7'h0, h > 0 && h < 2000});
        end_sim;
    end
endmodule

/* File: design/uart_frac_baud_error_check.sv */
`timescale 1ns/10ps
module uart_frac_baud_error_check (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // SFR port
    input wire uart_frac_pkg::sfr_req_s sfr,
    output logic [7:0] sfr_rdata,
    // Serial line
    input wire logic rxd,
    output logic txd,
    // Wake event
    output logic wake
);
    import uart_frac_pkg::*;

    uart_state_s s;
    uart_state_s n;
    logic pre_hit;
    logic frame_done;
    logic accept;
    logic stop_bit;
    logic ninth;
    logic mode9;
    logic ovr_set;

    function automatic logic [9:0] pow_mask(input logic [3:0] sh);
        pow_mask = (10'h001 << sh) - 10'h001;
    endfunction

    always_comb
    begin
        n = s;
        n.tick = 1'b0;
        n.wake = 1'b0;
        mode9 = s.port_ctrl[SC_MODE0];
        stop_bit = s.rx_s2;
        ninth = mode9 ? s.rx_shift[8] : stop_bit;
        frame_done = 1'b0;
        accept = 1'b0;
        ovr_set = 1'b0;

        // Pin synchroniser; first stage feeds only the second
        n.rx_s1 = rxd;
        n.rx_s2 = s.rx_s1;
        n.rx_prev = s.rx_s2;
        if (s.rx_prev && !s.rx_s2)
        begin
            n.wake = 1'b1;
        end

        // Software writes first, so hardware sets below win
        if (sfr.wr)
        begin
            case (sfr.addr)
                ADDR_SERIAL_PORT_CONTROL: n.port_ctrl = sfr.wdata;
                ADDR_BAUD_FRACTION: n.frac = sfr.wdata[5:0];
                ADDR_BAUD_TIMER_CONTROL:
                begin
                    n.baud_div = sfr.wdata[BT_EXT_LSB+1:BT_DIV_LSB];
                    n.frame_err = s.frame_err & sfr.wdata[BT_FRAME_ERR];
                    n.break_err = s.break_err & sfr.wdata[BT_BREAK_ERR];
                end
                ADDR_CHIP_CONFIGURATION:
                begin
                    n.ext_en = sfr.wdata[CFG_EXT_EN];
                    n.carrier_en = sfr.wdata[CFG_CARRIER];
                end
                ADDR_SERIAL_DATA_BUFFER:
                begin
                    // A write while a frame is going out is dropped
                    if (s.tx_st == TX_IDLE)
                    begin
                        n.tx_st = TX_BUSY;
                        n.tx_os = 4'h0;
                        n.tx_bits = 4'h0;
                        n.tx_shift = {1'b1, mode9 ? s.port_ctrl[SC_NINTH_TX] : 1'b1, sfr.wdata, 1'b0};
                    end
                end
                default: ;
            endcase
        end
        if (sfr.rd && sfr.addr == ADDR_SERIAL_DATA_BUFFER)
        begin
            n.ovr = 1'b0;
        end

        // Prescaler 2^(div+ext), then 64/(64+frac) fractional gate
        pre_hit = s.pre_cnt >= pow_mask(4'(s.baud_div[2:0]) + 4'(s.baud_div[4:3]));
        n.pre_cnt = pre_hit ? 10'h000 : s.pre_cnt + 10'h001;
        if (pre_hit)
        begin
            if (s.frac_acc + FRAC_STEPS >= FRAC_STEPS + {2'h0, s.frac})
            begin
                n.frac_acc = s.frac_acc + FRAC_STEPS - (FRAC_STEPS + {2'h0, s.frac});
                n.tick = 1'b1;
            end
            else
            begin
                n.frac_acc = s.frac_acc + FRAC_STEPS;
            end
        end

        // Receiver on 16x ticks
        if (s.tick)
        begin
            case (s.rx_st)
                RX_IDLE:
                begin
                    if (!s.rx_s2 && s.port_ctrl[SC_RX_EN])
                    begin
                        n.rx_st = RX_START;
                        n.rx_os = 4'h0;
                    end
                end
                RX_START:
                begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == SAMPLE_MID)
                    begin
                        // Glitch shorter than half a bit is ignored
                        n.rx_st = s.rx_s2 ? RX_IDLE : RX_DATA;
                        n.rx_os = 4'h0;
                        n.rx_bits = 4'h0;
                    end
                end
                RX_DATA:
                begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == OVERSAMPLE_LAST)
                    begin
                        n.rx_shift = {s.rx_s2, s.rx_shift[8:1]};
                        n.rx_bits = s.rx_bits + 4'h1;
                        if (s.rx_bits == (mode9 ? 4'h8 : 4'h7))
                        begin
                            n.rx_st = RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == OVERSAMPLE_LAST)
                    begin
                        n.rx_st = RX_IDLE;
                        frame_done = 1'b1;
                    end
                end
                default: n.rx_st = RX_IDLE;
            endcase
        end

        if (frame_done)
        begin
            // Classic: frame lost while flag pending; extended: taken even while flag pending
            accept = (!s.port_ctrl[SC_MP] || ninth) && (s.ext_en || !s.port_ctrl[SC_RX_DONE]);
            if (accept)
            begin
                n.rx_data = mode9 ? s.rx_shift[7:0] : s.rx_shift[8:1];
                n.port_ctrl[SC_NINTH_RX] = ninth;
                n.port_ctrl[SC_RX_DONE] = 1'b1;
                if (s.ext_en && s.port_ctrl[SC_RX_DONE])
                begin
                    ovr_set = 1'b1;
                    n.ovr = 1'b1;
                end
            end
            if (s.ext_en && !stop_bit)
            begin
                n.frame_err = 1'b1;
            end
        end

        // Break: low for more than a whole 9-bit frame
        if (!s.ext_en || s.rx_s2)
        begin
            n.brk_cnt = 8'h00;
        end
        else if (s.tick && s.brk_cnt != 8'hff)
        begin
            n.brk_cnt = s.brk_cnt + 8'h01;
            if (s.brk_cnt == BREAK_TICKS)
            begin
                n.break_err = 1'b1;
            end
        end

        // Transmitter
        if (s.tick && s.tx_st == TX_BUSY)
        begin
            n.tx_os = s.tx_os + 4'h1;
            if (s.tx_os == OVERSAMPLE_LAST)
            begin
                n.tx_shift = {1'b1, s.tx_shift[10:1]};
                n.tx_bits = s.tx_bits + 4'h1;
                if (s.tx_bits == (mode9 ? 4'h9 : 4'h8))
                begin
                    n.port_ctrl[SC_TX_DONE] = 1'b1;
                end
                if (s.tx_bits == (mode9 ? 4'ha : 4'h9))
                begin
                    n.tx_st = TX_IDLE;
                end
            end
        end

        // Carrier divider; free running so enabling it is glitch-safe
        if (s.car_cnt >= CARRIER_HALF_CYC - 11'h001)
        begin
            n.car_cnt = 11'h000;
            n.carrier = !s.carrier;
        end
        else
        begin
            n.car_cnt = s.car_cnt + 11'h001;
        end
        n.txd = n.tx_shift[0] | (n.carrier_en & n.carrier);

        if (sfr.rd)
        begin
            case (sfr.addr)
                ADDR_SERIAL_PORT_CONTROL: n.rdata = s.port_ctrl;
                ADDR_SERIAL_DATA_BUFFER: n.rdata = s.rx_data;
                ADDR_BAUD_FRACTION: n.rdata = {2'h0, s.frac};
                ADDR_BAUD_TIMER_CONTROL: n.rdata = {s.ovr, s.frame_err, s.break_err, s.baud_div};
                ADDR_CHIP_CONFIGURATION: n.rdata = {6'h00, s.carrier_en, s.ext_en};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.rx_st <= RX_IDLE;
            s.tx_st <= TX_IDLE;
            s.port_ctrl <= PORT_CTRL_RESET;
            s.baud_div <= BAUD_DIV_RESET;
            s.frac <= FRAC_RESET;
            s.tx_shift <= '1;
            s.txd <= 1'b1;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rx_prev <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign sfr_rdata = s.rdata;
    assign txd = s.txd;
    assign wake = s.wake;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    baud_tick_gate_a: assert property (s.tick |-> $past(pre_hit))
        else $error("baud tick without prescaler terminal count");
    frame_err_set_a: assert property (frame_done && s.ext_en && !stop_bit |=> s.frame_err)
        else $error("missing stop bit did not set framing error");
    break_set_a: assert property (s.ext_en && s.tick && !s.rx_s2 && s.brk_cnt == BREAK_TICKS |=> s.break_err)
        else $error("long low line did not set break error");
    ext_accept_a: assert property (frame_done && s.ext_en && !s.port_ctrl[SC_MP] |=> s.port_ctrl[SC_RX_DONE])
        else $error("extended mode dropped a frame");
    ovr_set_a: assert property (frame_done && accept && s.ext_en && s.port_ctrl[SC_RX_DONE] |=> s.ovr)
        else $error("overwrite did not set overwrite flag");
    ovr_clear_a: assert property (sfr.rd && sfr.addr == ADDR_SERIAL_DATA_BUFFER && !ovr_set |=> !s.ovr)
        else $error("data buffer read did not clear overwrite flag");
    ext_gate_a: assert property (!s.ext_en && !s.frame_err && !s.ovr |=> !s.frame_err && !s.ovr)
        else $error("error flag set with extended mode off");
    mp_reject_a: assert property (frame_done && !mode9 && s.port_ctrl[SC_MP] && !stop_bit && !s.port_ctrl[SC_RX_DONE]
        && !(sfr.wr && sfr.addr == ADDR_SERIAL_PORT_CONTROL) |=> !s.port_ctrl[SC_RX_DONE])
        else $error("frame without stop bit accepted in multiprocessor mode");
    ninth_stop_a: assert property (accept && !mode9 |=> s.port_ctrl[SC_NINTH_RX] == $past(s.rx_s2))
        else $error("stop bit not latched into ninth bit");
    wake_edge_a: assert property (s.rx_prev && !s.rx_s2 |=> wake)
        else $error("receive line activity gave no wake pulse");
    classic_drop_a: assert property (frame_done && !s.ext_en && s.port_ctrl[SC_RX_DONE] |=> $stable(s.rx_data))
        else $error("classic mode overwrote pending byte");
endmodule

/* File: design/uart_frac_pkg.sv */
package uart_frac_pkg;
    // Register offsets on the SFR port
    localparam logic [7:0] ADDR_SERIAL_PORT_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER = 8'h99;
    localparam logic [7:0] ADDR_BAUD_FRACTION = 8'h9d;
    localparam logic [7:0] ADDR_BAUD_TIMER_CONTROL = 8'h9e;
    localparam logic [7:0] ADDR_CHIP_CONFIGURATION = 8'haf;

    // serial_port_control fields
    localparam int SC_MODE0 = 7;
    localparam int SC_MODE1 = 6;
    localparam int SC_MP = 5;
    localparam int SC_RX_EN = 4;
    localparam int SC_NINTH_TX = 3;
    localparam int SC_NINTH_RX = 2;
    localparam int SC_TX_DONE = 1;
    localparam int SC_RX_DONE = 0;

    // baud_timer_control fields
    localparam int BT_OVR = 7;
    localparam int BT_FRAME_ERR = 6;
    localparam int BT_BREAK_ERR = 5;
    localparam int BT_EXT_LSB = 3;
    localparam int BT_DIV_LSB = 0;

    // chip_configuration fields
    localparam int CFG_EXT_EN = 0;
    localparam int CFG_CARRIER = 1;

    // Reset values
    localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
    localparam logic [4:0] BAUD_DIV_RESET = 5'h00;
    localparam logic [5:0] FRAC_RESET = 6'h00;

    // Timing
    localparam logic [7:0] FRAC_STEPS = 8'h40;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam int BREAK_BITS = 11;
    localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * 16);
    localparam int CLK_HZ = 125000000;
    localparam int CARRIER_HZ = 38000;
    localparam logic [10:0] CARRIER_HALF_CYC = 11'(CLK_HZ / (2 * CARRIER_HZ));

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } tx_e;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        rx_e rx_st;
        tx_e tx_st;
        logic [7:0] port_ctrl;
        logic [7:0] rx_data;
        logic [5:0] frac;
        logic [4:0] baud_div;
        logic frame_err;
        logic break_err;
        logic ovr;
        logic ext_en;
        logic carrier_en;
        logic [9:0] pre_cnt;
        logic [7:0] frac_acc;
        logic tick;
        logic [3:0] rx_os;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic [3:0] tx_os;
        logic [3:0] tx_bits;
        logic [10:0] tx_shift;
        logic [7:0] brk_cnt;
        logic [10:0] car_cnt;
        logic carrier;
        logic txd;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic wake;
        logic [7:0] rdata;
    } uart_state_s;
endpackage
